// ---- include/mcs_pkg.sv ----
// Function
// - the sample phase restarts when the sync reset is released, so all converters line up.
// - after power-on the single-ended sync reset input is selected, select bit 14 low.
// - with select bit 14 set, the sync reset is taken from the differential pair.
// - the sync reset may be asserted at any time, unaligned to the sample clock.
// - release is aligned to a rising edge; the phase restarts at the next falling edge (here one rising-edge restart cycle stands in).
// - valid data is delayed by an amount that grows with the sync reset pulse length.
package mcs_pkg;
  localparam int unsigned MCS_SEL_BIT      = 14;
  localparam logic        MCS_SEL_RESET    = 1'h0;
  localparam int unsigned MCS_PHASE_W      = 1;
  localparam int unsigned MCS_SETTLE_W     = 8;
  localparam logic [7:0]  MCS_SETTLE_BASE  = 8'h04;
  localparam logic [7:0]  MCS_SETTLE_MAX   = 8'hFF;

  typedef struct packed {
    logic       selMeta;
    logic       selSync;
    logic       posMeta;
    logic       posSync;
    logic       pairPMeta;
    logic       pairPSync;
    logic       pairNMeta;
    logic       pairNSync;
    logic       inReset;
    logic [7:0] pulseLen;
    logic [7:0] settleCnt;
    logic       phase;
    logic       dataValid;
    logic       phaseRestart;
  } mcs_state_t;
endpackage : mcs_pkg

// ---- hdl/mcs_sync_reset.sv ----
`timescale 1ns/1ps
module mcs_sync_reset
  import mcs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic differential_sync_reset_select,
  input  wire logic sample_phase_sync_reset,
  input  wire logic sample_phase_sync_reset_p,
  input  wire logic sample_phase_sync_reset_n,
  output logic      syncResetActive,
  output logic      samplePhase,
  output logic      phaseRestart,
  output logic      dataValid
);
  mcs_state_t state_reg;
  mcs_state_t state_next;
  logic       chosen;
  logic       pairLevel;
  logic       phaseNext;
  logic       validNext;
  logic [7:0] pulseNext;
  logic [7:0] settleLoad;
  logic [7:0] settleNext;
  logic       settleDone;

  // pair reads as asserted only with p high and n low, so a grounded
  // pair reads as released
  function automatic logic mcs_pair_level
  (
    input logic posLevel,
    input logic negLevel
  );
    logic level;
    level = posLevel & ~negLevel;
    return level;
  endfunction : mcs_pair_level

  // select low takes single-ended pin only high takes pair
  function automatic logic mcs_pick
  (
    input logic useDiff,
    input logic pairSync,
    input logic singleSync
  );
    logic picked;
    if (useDiff)
    begin
      picked = pairSync;
    end
    else
    begin
      picked = singleSync;
    end
    return picked;
  endfunction : mcs_pick

  // saturates, so a reset held for ages cannot wrap to a short wait
  function automatic logic [7:0] mcs_sat_inc
  (
    input logic [7:0] value
  );
    logic [7:0] result;
    if (value != MCS_SETTLE_MAX)
    begin
      result = value + 8'h01;
    end
    else
    begin
      result = value;
    end
    return result;
  endfunction : mcs_sat_inc

  // wait grows with pulse length, capped at the counter's range
  function automatic logic [7:0] mcs_settle_load
  (
    input logic [7:0] pulse
  );
    logic [7:0] load;
    if (pulse > (MCS_SETTLE_MAX - MCS_SETTLE_BASE))
    begin
      load = MCS_SETTLE_MAX;
    end
    else
    begin
      load = pulse + MCS_SETTLE_BASE;
    end
    return load;
  endfunction : mcs_settle_load

  // stops at zero so valid data stays up until the next sync reset
  function automatic logic [7:0] mcs_count_down
  (
    input logic [7:0] count
  );
    logic [7:0] result;
    if (count != 8'h00)
    begin
      result = count - 8'h01;
    end
    else
    begin
      result = count;
    end
    return result;
  endfunction : mcs_count_down

  // phase parked low while held and in the restart cycle
  function automatic logic mcs_phase_step
  (
    input logic held,
    input logic releasing,
    input logic phaseNow
  );
    logic result;
    if (held || releasing)
    begin
      result = 1'b0;
    end
    else
    begin
      result = ~phaseNow;
    end
    return result;
  endfunction : mcs_phase_step

  // valid drops at once on a reset, rises only once settling is over
  function automatic logic mcs_valid_step
  (
    input logic held,
    input logic done,
    input logic validNow
  );
    logic result;
    if (held)
    begin
      result = 1'b0;
    end
    else if (done)
    begin
      result = 1'b1;
    end
    else
    begin
      result = validNow;
    end
    return result;
  endfunction : mcs_valid_step

  assign pairLevel  = mcs_pair_level(state_reg.pairPSync,
                                     state_reg.pairNSync);
  assign chosen     = mcs_pick(state_reg.selSync, pairLevel,
                               state_reg.posSync);
  assign pulseNext  = mcs_sat_inc(state_reg.pulseLen);
  assign settleLoad = mcs_settle_load(state_reg.pulseLen);
  assign settleNext = mcs_count_down(state_reg.settleCnt);
  assign settleDone = (state_reg.settleCnt == 8'h00);
  assign phaseNext  = mcs_phase_step(chosen, state_reg.inReset,
                                     state_reg.phase);
  assign validNext  = mcs_valid_step(chosen | state_reg.inReset,
                                     settleDone, state_reg.dataValid);

  always_comb
  begin
    state_next = state_reg;
    // only the second flop of each pin is read by logic
    state_next.selMeta      = differential_sync_reset_select;
    state_next.selSync      = state_reg.selMeta;
    state_next.posMeta      = sample_phase_sync_reset;
    state_next.posSync      = state_reg.posMeta;
    state_next.pairPMeta    = sample_phase_sync_reset_p;
    state_next.pairPSync    = state_reg.pairPMeta;
    state_next.pairNMeta    = sample_phase_sync_reset_n;
    state_next.pairNSync    = state_reg.pairNMeta;
    state_next.phaseRestart = 1'b0;
    state_next.phase        = phaseNext;
    state_next.dataValid    = validNext;
    if (chosen)
    begin
      // level seen whenever it arrives, no edge alignment needed
      state_next.inReset  = 1'b1;
      state_next.pulseLen = pulseNext;
    end
    else if (state_reg.inReset)
    begin
      // one clock only: this cycle stands in for the falling-edge resync
      state_next.inReset      = 1'b0;
      state_next.phaseRestart = 1'b1;
      state_next.settleCnt    = settleLoad;
      state_next.pulseLen     = 8'h00;
    end
    else
    begin
      state_next.settleCnt = settleNext;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg.selMeta      <= MCS_SEL_RESET;
      state_reg.selSync      <= MCS_SEL_RESET;
      state_reg.posMeta      <= 1'b0;
      state_reg.posSync      <= 1'b0;
      state_reg.pairPMeta    <= 1'b0;
      state_reg.pairPSync    <= 1'b0;
      state_reg.pairNMeta    <= 1'b0;
      state_reg.pairNSync    <= 1'b0;
      state_reg.inReset      <= 1'b0;
      state_reg.pulseLen     <= 8'h00;
      state_reg.settleCnt    <= 8'h00;
      state_reg.phase        <= 1'b0;
      state_reg.dataValid    <= 1'b0;
      state_reg.phaseRestart <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign syncResetActive = state_reg.inReset;
  assign samplePhase     = state_reg.phase;
  assign phaseRestart    = state_reg.phaseRestart;
  assign dataValid       = state_reg.dataValid;
endmodule : mcs_sync_reset

// ---- tb/mcs_props.sv ----
`timescale 1ns/1ps
module mcs_props(input logic ref_clk,rst,syncResetActive,samplePhase,
  phaseRestart,dataValid);
  default clocking @(posedge ref_clk);endclocking
  default disable iff(rst);
  wire a=syncResetActive,r=phaseRestart,v=dataValid,p=samplePhase;
  restart_edge_a:assert property($fell(a)==r)else $error("r");
  one_shot_a:assert property(r|=>!r)else $error("w");
  phase_zero_a:assert property(r|->!p##1 p##1!p)else $error("p");
  valid_wait_a:assert property(r|->!v[*5])else $error("v");
  valid_hold_a:assert property(a|->!v)else $error("h");
  valid_toggle_a:assert property(v&&$past(v)|->p!=$past(p))else $error("t");
  cover property(r);
  cover property(a);
  cover property(v);
endmodule : mcs_props
bind mcs_sync_reset mcs_props props(.*);

// ---- tb/mcs_ctrl.sv ----
`timescale 1ns/1ps
module mcs_ctrl(input logic ref_clk,output logic s=0,p=0,n=1);
  task pulse(int m,bit x);
    @(negedge ref_clk){s,p,n}={x,!x,x}; // unaligned on purpose
    repeat(m)@(posedge ref_clk);
    {s,p,n}<=3'h1; // freed on a rising edge
  endtask : pulse
endmodule : mcs_ctrl

// ---- tb/multi_converter_clock_sync_bench.sv ----
`timescale 1ns/1ps
module multi_converter_clock_sync_bench;
  logic ref_clk=0,rst=1,differential_sync_reset_select=0,s,p,n;
  logic syncResetActive,samplePhase,phaseRestart,dataValid;
  int err_count=0,checks=0,cyc=0,k,m;
  always #10 ref_clk=~ref_clk;
  mcs_ctrl ctl(.*);
  mcs_sync_reset uut(.sample_phase_sync_reset(s),
    .sample_phase_sync_reset_p(p),.sample_phase_sync_reset_n(n),.*);
  task chk(bit ok);
    checks++;
    if(!ok)begin err_count++;$display("[ERR] %0t bad",$time);end
  endtask : chk
  task stop_test;
    $display("%0d errors %0d checks",err_count,checks);
    if(err_count==0&&checks>0)$display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk)if(++cyc>4000)begin err_count++;stop_test;end
  initial begin
    void'($urandom(38221));
    repeat(8)@(negedge ref_clk);
    rst=0;
    for(int i=0;i<6;i++)begin
      differential_sync_reset_select=i[0];
      m=3+$urandom%8;
      // select crosses two flops first
      repeat(4)@(negedge ref_clk);
      ctl.pulse(m,(i<4)^i[0]);
      @(negedge ref_clk);
      chk(syncResetActive===(i<4));
      for(k=0;phaseRestart!==1&&k<9;k++)@(negedge ref_clk);
      chk((k==3)==(i<4));
      chk(i>=4||(samplePhase===0&&syncResetActive===0));
      if(i<4)begin
        for(k=0;dataValid!==1&&k<300;k++)@(negedge ref_clk);
        chk(k==m+5);
      end
      $display("test %0d done",i);
    end
    stop_test;
  end
endmodule : multi_converter_clock_sync_bench
